// >>> verilog/tlb_logic_block.sv
/*
 Three-input logic function block.
 Each percentage input passes a hysteresis comparator into a held level; the selected inversion
 is applied, unconnected inputs are dropped, and the chosen Boolean operation drives a registered
 0 or 100 percent output together with the bare logic result.
 An input presented before edge N shows at the outputs after edge N+1.
 Assumes inputs come from logic on i_core_clk, so no synchroniser is placed on them.
 Assumes configuration is static or changes between evaluations.
*/
`timescale 1ns/1ps
module tlb_logic_block
    import tlb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire tlb_inputs_t i_inputs,
    input wire tlb_config_t i_config,
    output logic signed [15:0] o_output,
    output logic o_result
);
    logic [2:0] level;
    logic [2:0] func_ff;
    logic [2:0] invert_ff;
    logic [2:0] conn_ff;

    // Stages between the held levels and the result register
    logic [2:0] flip;
    logic [2:0] oriented;
    logic or_term;
    logic and_term;
    logic odd_term;
    logic nxt_result;
    logic signed [15:0] nxt_output;

    logic result_ff;
    logic signed [15:0] out_ff;

    // One comparator per input, bit 0 is A
    tlb_hyst u_hyst_a (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_value(i_inputs.first_input_source),
        .o_level(level[0])
    );

    tlb_hyst u_hyst_b (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_value(i_inputs.second_input_source),
        .o_level(level[1])
    );

    tlb_hyst u_hyst_c (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_value(i_inputs.third_input_source),
        .o_level(level[2])
    );

    // Function select, OR after reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            func_ff <= TLB_FUNC_RESET;
        end else begin
            func_ff <= i_config.logic_function_select;
        end
    end

    // Inversion code, none after reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            invert_ff <= TLB_INVERT_RESET;
        end else begin
            invert_ff <= i_config.input_invert_code;
        end
    end

    // Connected flags
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            conn_ff <= TLB_LEVEL_RESET;
        end else begin
            conn_ff <= i_config.input_connected;
        end
    end

    // Weight 1 flips A, weight 2 flips B, weight 4 flips C
    function automatic logic [2:0] tlb_flip_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        m[0] = code[TLB_INV_A_BIT];
        m[1] = code[TLB_INV_B_BIT];
        m[2] = code[TLB_INV_C_BIT];
        return m;
    endfunction : tlb_flip_mask

    // OR over the connected inputs; an empty set gives 0
    function automatic logic tlb_any(
        input logic [2:0] v,
        input logic [2:0] conn
    );
        logic acc;
        acc = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (conn[i]) begin
                acc = acc | v[i];
            end
        end
        return acc;
    endfunction : tlb_any

    // AND over the connected inputs; an empty set gives 1
    function automatic logic tlb_all(
        input logic [2:0] v,
        input logic [2:0] conn
    );
        logic acc;
        acc = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (conn[i]) begin
                acc = acc & v[i];
            end
        end
        return acc;
    endfunction : tlb_all

    // Odd parity over the connected inputs; XNOR takes its complement
    function automatic logic tlb_odd(
        input logic [2:0] v,
        input logic [2:0] conn
    );
        logic acc;
        acc = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (conn[i]) begin
                acc = acc ^ v[i];
            end
        end
        return acc;
    endfunction : tlb_odd

    // Codes 6 and 7 are undefined and read as false
    function automatic logic tlb_pick(
        input logic [2:0] func,
        input logic any_v,
        input logic all_v,
        input logic odd_v
    );
        logic r;
        r = 1'b0;
        unique case (func)
            TLB_OP_OR: begin
                r = any_v;
            end
            TLB_OP_AND: begin
                r = all_v;
            end
            TLB_OP_XOR: begin
                r = odd_v;
            end
            TLB_OP_NOR: begin
                r = ~any_v;
            end
            TLB_OP_NAND: begin
                r = ~all_v;
            end
            TLB_OP_XNOR: begin
                r = ~odd_v;
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction : tlb_pick

    // Full scale for a true result, zero for false
    function automatic logic signed [15:0] tlb_scale(input logic r);
        logic signed [15:0] s;
        s = TLB_ZERO_SCALE;
        if (r) begin
            s = TLB_FULL_SCALE;
        end
        return s;
    endfunction : tlb_scale

    // Inversion sits between the comparators and the operation
    always_comb begin
        flip = tlb_flip_mask(invert_ff);
        oriented = level ^ flip;
    end

    // Unconnected inputs drop out of every reduction
    always_comb begin
        or_term = tlb_any(oriented, conn_ff);
        and_term = tlb_all(oriented, conn_ff);
        odd_term = tlb_odd(oriented, conn_ff);
    end

    always_comb begin
        nxt_result = tlb_pick(func_ff, or_term, and_term, odd_term);
        nxt_output = tlb_scale(nxt_result);
    end

    // One evaluation registered per clock
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            result_ff <= 1'b0;
        end else begin
            result_ff <= nxt_result;
        end
    end

    // Scaled output, registered beside the result
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            out_ff <= TLB_ZERO_SCALE;
        end else begin
            out_ff <= nxt_output;
        end
    end

    assign o_output = out_ff;
    assign o_result = result_ff;
endmodule : tlb_logic_block

// >>> verilog/tlb_pkg.sv
/*
 Package for the three-input logic block: value format, thresholds, function codes, carrier types.
 Assumes percentages arrive as signed hundredths of a percent (10000 = 100.00%).
*/
// Overview of operation
// - Unconnected inputs are left out of operation
// - Codes 0..5: OR AND XOR NOR NAND XNOR
// - True drives 100 percent, false drives 0
// - Hysteresis: below 70 low, above 80 high
// - XOR is odd parity, XNOR its complement
// - Invert code weights 1=A, 2=B, 4=C
package tlb_pkg;
    localparam int TLB_PCT_W = 16;
    localparam logic signed [15:0] TLB_LOW_THRESH = 16'h1B58;  // 70.00%
    localparam logic signed [15:0] TLB_HIGH_THRESH = 16'h1F40; // 80.00%
    localparam logic signed [15:0] TLB_FULL_SCALE = 16'h2710;  // 100.00%
    localparam logic signed [15:0] TLB_ZERO_SCALE = 16'h0000;
    localparam logic [2:0] TLB_FUNC_RESET = 3'h0;
    localparam logic [2:0] TLB_INVERT_RESET = 3'h0;
    localparam logic [2:0] TLB_LEVEL_RESET = 3'h0;
    localparam int TLB_INV_A_BIT = 0;
    localparam int TLB_INV_B_BIT = 1;
    localparam int TLB_INV_C_BIT = 2;

    typedef enum logic [2:0] {
        TLB_OP_OR = 3'h0,
        TLB_OP_AND = 3'h1,
        TLB_OP_XOR = 3'h2,
        TLB_OP_NOR = 3'h3,
        TLB_OP_NAND = 3'h4,
        TLB_OP_XNOR = 3'h5
    } tlb_op_t;

    typedef struct packed {
        logic signed [15:0] first_input_source;
        logic signed [15:0] second_input_source;
        logic signed [15:0] third_input_source;
    } tlb_inputs_t;

    typedef struct packed {
        logic [2:0] logic_function_select;
        logic [2:0] input_invert_code;
        logic [2:0] input_connected;
    } tlb_config_t;
endpackage : tlb_pkg

// >>> verilog/tlb_hyst.sv
/*
 One hysteresis comparator turning a percentage into a held logic level.
 Assumes a same-clock input and synchronous active-high reset.
*/
`timescale 1ns/1ps
module tlb_hyst
    import tlb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic signed [15:0] i_value,
    output logic o_level
);
    logic level_ff;
    logic nxt_level;

    always_comb begin
        nxt_level = level_ff;
        if (i_value < TLB_LOW_THRESH) begin
            nxt_level = 1'b0;
        end else if (i_value > TLB_HIGH_THRESH) begin
            nxt_level = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            level_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
        end
    end

    assign o_level = level_ff;
endmodule : tlb_hyst

// >>> bench/tlb_src.sv
/* Source blocks feeding the logic block.
 Assumes values arrive in hundredths of a percent. */
`timescale 1ns/1ps
module tlb_src
    import tlb_pkg::*;
(
    input wire logic signed [15:0] i_a,
    input wire logic signed [15:0] i_b,
    input wire logic signed [15:0] i_c,
    output tlb_inputs_t o_inputs
);
    assign o_inputs = {i_a, i_b, i_c};
endmodule : tlb_src

// >>> bench/tlb_chk_sva.sv
/* Port checker for the logic block.
 Assumes the ports of tlb_logic_block. */
`timescale 1ns/1ps
module tlb_chk
    import tlb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire tlb_inputs_t i_inputs,
    input wire tlb_config_t i_config,
    input wire logic signed [15:0] o_output,
    input wire logic o_result
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    scale_map_a: assert property (o_output == (o_result ? TLB_FULL_SCALE : TLB_ZERO_SCALE))
        else $error("output scale does not follow result");
    rst_clear_a: assert property ($past(i_reset) |-> !o_result) else $error("result set after reset");
    // The result seen at an edge comes from inputs and configuration sampled two edges before
    none_or_a: assert property (!$past(i_reset) && !$past(i_reset, 2)
        && $past(i_config, 2) == 9'h000 |-> !o_result)
        else $error("or over no inputs not false");
    none_and_a: assert property (!$past(i_reset) && !$past(i_reset, 2)
        && $past(i_config, 2) == 9'h040 |-> o_result)
        else $error("and over no inputs not true");
    high_in_a: assert property (!$past(i_reset) && !$past(i_reset, 2)
        && $past(i_config, 2) == 9'h001
        && $past(i_inputs.first_input_source, 2) > TLB_HIGH_THRESH |-> o_result)
        else $error("high input not read as one");
    low_in_a: assert property (!$past(i_reset) && !$past(i_reset, 2)
        && $past(i_config, 2) == 9'h001
        && $past(i_inputs.first_input_source, 2) < TLB_LOW_THRESH |-> !o_result)
        else $error("low input not read as zero");
    xnor_one_a: assert property (!$past(i_reset) && !$past(i_reset, 2)
        && $past(i_config, 2) == 9'h141
        && $past(i_inputs.first_input_source, 2) > TLB_HIGH_THRESH |-> !o_result)
        else $error("xnor of one high input not false");
    inv_one_a: assert property (!$past(i_reset) && !$past(i_reset, 2)
        && $past(i_config, 2) == 9'h009
        && $past(i_inputs.first_input_source, 2) > TLB_HIGH_THRESH |-> !o_result)
        else $error("inverted high input not false");
endmodule : tlb_chk
bind tlb_logic_block tlb_chk tlb_chk_i (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_inputs(i_inputs),
    .i_config(i_config), .o_output(o_output), .o_result(o_result));

// >>> bench/tb.sv
/* Bench for the logic block: case table, hysteresis, reset.
 Assumes the checker is bound. */
`timescale 1ns/1ps
module tb;
    import tlb_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic signed [15:0] pa = 16'h0000;
    logic signed [15:0] pb = 16'h0000;
    logic signed [15:0] pc = 16'h0000;
    tlb_config_t cfg = '0;
    tlb_inputs_t ins;
    logic signed [15:0] o_output;
    logic o_result;
    int err_count = 0;
    int compares = 0;
    // Rows: function, invert, connected, levels C..A, expected
    logic [12:0] rows [15] = '{13'h0070, 13'h0079, 13'h047F, 13'h0476, 13'h0401, 13'h087F, 13'h083E,
        13'h0C71, 13'h107E, 13'h1412, 13'h1477, 13'h0092, 13'h057B, 13'h03FE, 13'h187E};
    logic signed [15:0] hv [7] = '{16'h1D4C, 16'h1F40, 16'h1B58, 16'h1B57, 16'h1D4C, 16'h1F40, 16'h1F41};
    logic [0:6] hexp = 7'b1110001;
    tlb_src tlb_src_i (.i_a(pa), .i_b(pb), .i_c(pc), .o_inputs(ins));
    tlb_logic_block tlb_logic_block_i (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_inputs(ins),
        .i_config(cfg), .o_output(o_output), .o_result(o_result));
    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string n, input logic e);
        logic signed [15:0] s;
        s = e ? TLB_FULL_SCALE : TLB_ZERO_SCALE;
        compares++;
        if (o_result !== e) begin
            err_count++;
            $display("ERROR %s result exp %b got %b", n, e, o_result);
        end
        compares++;
        if (o_output !== s) begin
            err_count++;
            $display("ERROR %s output exp %0d got %0d", n, s, o_output);
        end
    endtask : chk
    task automatic put(input tlb_config_t k, input logic [2:0] l);
        @(posedge i_core_clk);
        cfg <= k;
        pa <= l[0] ? 16'h2328 : 16'h1388;
        pb <= l[1] ? 16'h2328 : 16'h1388;
        pc <= l[2] ? 16'h2328 : 16'h1388;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : put
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #4000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_reset <= 1'b0;
        foreach (rows[i]) begin
            put(rows[i][12:4], rows[i][3:1]);
            chk("row", rows[i][0]);
        end
        $display("table done");
        put(9'h001, 3'b001);
        foreach (hv[i]) begin
            @(posedge i_core_clk);
            pa <= hv[i];
            repeat (2) @(posedge i_core_clk);
            #1;
            chk("hyst", hexp[i]);
        end
        $display("hysteresis done");
        put(9'h001, 3'b001);
        chk("pre_reset", 1'b1);
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        pa <= 16'h1D4C;
        @(posedge i_core_clk);
        #1;
        chk("in_reset", 1'b0);
        @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("held_clear", 1'b0);
        $display("reset done");
        wrap_up();
    end
endmodule : tb
